// file: src/vcic_pkg.sv
// Purpose: constants for the virtual interface control block
// Assumes: one 25 MHz clock, synchronous active-high reset
// Notes:   encodings are op0/op1/CRn/CRm/op2 of the system register access
package vcic_pkg;
  // system register encoding
  localparam logic [1:0] ENC_OP0   = 2'h3;
  localparam logic [2:0] ENC_OP1   = 3'h4;
  localparam logic [3:0] ENC_CRN   = 4'hc;
  localparam logic [3:0] ENC_CRM   = 4'hb;
  localparam logic [2:0] OP2_TYPE  = 3'h1;
  localparam logic [2:0] OP2_MAINT = 3'h2;
  localparam logic [2:0] OP2_CTRL  = 3'h7;
  // control field positions
  localparam int PMR_LSB  = 24;
  localparam int BP0_LSB  = 21;
  localparam int BP1_LSB  = 18;
  localparam int EOIM_BIT = 9;
  localparam int CBP_BIT  = 4;
  localparam int FIQ_BIT  = 3;
  localparam int ACK_BIT  = 2;
  localparam int EN1_BIT  = 1;
  localparam int EN0_BIT  = 0;
  // type field positions
  localparam int PRI_LSB  = 29;
  localparam int PRE_LSB  = 26;
  localparam int IDW_LSB  = 23;
  localparam int SEI_BIT  = 22;
  localparam int A3V_BIT  = 21;
  localparam int NDI_BIT  = 20;
  localparam int TDS_BIT  = 19;
  localparam int LRC_LSB  = 0;
  // values
  localparam logic [2:0] BP_MAX       = 3'h7;
  localparam logic [2:0] IDW_16       = 3'h0;
  localparam logic [2:0] IDW_24       = 3'h1;
  localparam logic [23:0] SPURIOUS_G1 = 24'h0003fe;
  localparam logic [7:0] PMR_RESET    = 8'h00;
  localparam logic [2:0] BP0_RESET    = 3'h2;
  localparam logic [2:0] BP1_RESET    = 3'h3;
  localparam int MIN_PRI_BITS         = 5;
  typedef enum logic [1:0] {vcic_idle_type, vcic_read_type, vcic_trap_type} vcic_resp_type;
endpackage

// file: src/vcic_prio_if.sv
// Purpose: carrier between control block and preemption checker
// Assumes: single clock domain
// Notes:   purely combinational signals
`timescale 1ns/100ps
`default_nettype none
interface vcic_prio_if;
  logic [7:0] mask;
  logic [2:0] point0;
  logic [2:0] point1;
  logic       common;
  logic [7:0] cand_prio;
  logic [7:0] run_prio;
  logic       cand_group1;
  logic       may_signal;
  modport ctrl (output mask, point0, point1, common, cand_prio, run_prio, cand_group1, input may_signal);
  modport chk  (input mask, point0, point1, common, cand_prio, run_prio, cand_group1, output may_signal);
endinterface
`default_nettype wire

// file: src/vcic_prio_check.sv
// Purpose: decides whether a pending virtual interrupt may be signalled
// Assumes: lower number means higher priority
// Notes:   group priority is the bits above the binary point
`timescale 1ns/100ps
`default_nettype none
module vcic_prio_check (
  vcic_prio_if.chk pif
);
  function automatic logic [7:0] vcic_group_prio(input logic [7:0] p, input logic [2:0] bp);
    logic [7:0] m;
    // four-bit shift count so a point of 7 clears the whole group field instead of wrapping
    m = 8'hff << ({1'b0, bp} + 4'h1);
    return p & m;
  endfunction
  logic [2:0] point;
  always_comb begin
    // common mode makes group 0 point govern group 1 too
    point = (pif.cand_group1 && !pif.common) ? pif.point1 : pif.point0;
    pif.may_signal = (pif.cand_prio < pif.mask) &&
                     (vcic_group_prio(pif.cand_prio, point) < vcic_group_prio(pif.run_prio, point));
  end
endmodule
`default_nettype wire

// file: src/vcic_ctrl.sv
// Purpose: hypervisor control and type registers of a virtual interrupt interface
// Assumes: system register requests arrive synchronous to ref_clk, one per cycle
// Notes:   guest-side register ports alias the same state as the hypervisor view
// How it works
// - interrupt signalled only when its priority beats the 8-bit mask
// - control fields alias guest registers; writes via either path visible in both, group 1 point only while common mode is off
// - group 0 binary point sets group 0 preemption, group 1 too in common mode
// - group 1 binary point sets group 1 preemption when common mode is off
// - split mode off: end-of-interrupt drops priority and deactivates
// - split mode on: end-of-interrupt only drops; deactivation register deactivates
// - common mode off: each group uses its own binary point
// - common mode on: guest group 1 point reads group 0 plus one saturated, guest writes ignored
// - group 0 goes out as fast interrupt when route bit set, else normal
// - ack control clear: group 1 highest pending reads give identifier 1022
// - group 1 signalling only while group 1 enable is set
// - group 0 signalling only while group 0 enable is set
// - hypervisor accesses trap while system register enable is clear
// - decode type, maintenance status and control encodings
// - type reports priority bits minus one, at least five
// - type reports preemption bits minus one, at least five
// - identifier width field reads 000 or 001 only
// - type bit reports system error support
// - type bit reports top affinity nonzero support
// - type bit set when direct injection unsupported
// - type bit reports deactivate trap support
// - type reports list register count minus one
`timescale 1ns/100ps
`default_nettype none
module vcic_ctrl #(
  parameter int   PRI_BITS   = 5,
  parameter int   PRE_BITS   = 5,
  parameter bit   ID24       = 1'b0,
  parameter bit   SEI_SUP    = 1'b0,
  parameter bit   A3V_SUP    = 1'b0,
  parameter bit   NO_DIRECT  = 1'b1,
  parameter bit   TDS_SUP    = 1'b0,
  parameter int   LIST_REGS  = 4,
  parameter bit   SRE_ALWAYS = 1'b0
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // hypervisor system register port
  input  wire logic        sr_valid,
  input  wire logic        sr_write,
  input  wire logic [1:0]  sr_op0,
  input  wire logic [2:0]  sr_op1,
  input  wire logic [3:0]  sr_crn,
  input  wire logic [3:0]  sr_crm,
  input  wire logic [2:0]  sr_op2,
  input  wire logic [31:0] sr_wdata,
  input  wire logic        sysreg_enable_hyp,
  input  wire logic [31:0] maintenance_status,
  output logic             sr_done,
  output logic             sr_trap,
  output logic [31:0]      sr_rdata,
  // guest view registers
  input  wire logic        pmr_wr,
  input  wire logic        bp0_wr,
  input  wire logic        bp1_wr,
  input  wire logic [7:0]  guest_wdata,
  output logic [7:0]       priority_mask_register,
  output logic [2:0]       group0_point_register,
  output logic [2:0]       group1_point_register,
  // end of interrupt and deactivation
  input  wire logic        group0_end_of_interrupt,
  input  wire logic        group1_end_of_interrupt,
  input  wire logic        deactivation_register,
  output logic             prio_drop,
  output logic             deactivate,
  // pending candidate and acknowledge
  input  wire logic        cand_valid,
  input  wire logic        cand_group1,
  input  wire logic [7:0]  cand_prio,
  input  wire logic [23:0] cand_id,
  input  wire logic [7:0]  run_prio,
  output logic [23:0]      ack_id,
  output logic             virq,
  output logic             vfiq
);
  localparam logic [31:0] TYPE_VALUE =
    (32'((PRI_BITS - 1) & 7) << vcic_pkg::PRI_LSB) |
    (32'((PRE_BITS - 1) & 7) << vcic_pkg::PRE_LSB) |
    (32'(ID24 ? vcic_pkg::IDW_24 : vcic_pkg::IDW_16) << vcic_pkg::IDW_LSB) |
    (32'(SEI_SUP) << vcic_pkg::SEI_BIT) |
    (32'(A3V_SUP) << vcic_pkg::A3V_BIT) |
    (32'(NO_DIRECT) << vcic_pkg::NDI_BIT) |
    (32'(TDS_SUP) << vcic_pkg::TDS_BIT) |
    (32'((LIST_REGS - 1) & 31) << vcic_pkg::LRC_LSB);

  typedef struct packed {
    logic [7:0]  mask;
    logic [2:0]  point0;
    logic [2:0]  point1;
    logic        split;
    logic        common;
    logic        fast;
    logic        ack;
    logic        en1;
    logic        en0;
    logic        done;
    logic        trap;
    logic [31:0] rdata;
    logic        drop;
    logic        deact;
    logic [23:0] ackid;
    logic        irq;
    logic        fiq;
  } vcic_state_type;

  vcic_state_type state;
  vcic_state_type next_state;
  vcic_prio_if    pif ();

  function automatic logic [2:0] vcic_bp1_view(input logic [2:0] b0, input logic [2:0] b1, input logic cm);
    if (cm) begin
      return (b0 == vcic_pkg::BP_MAX) ? vcic_pkg::BP_MAX : b0 + 3'h1;
    end
    return b1;
  endfunction

  function automatic logic [31:0] vcic_ctrl_word(input vcic_state_type s);
    logic [31:0] w;
    w = 32'h0;
    w[vcic_pkg::PMR_LSB +: 8] = s.mask;
    w[vcic_pkg::BP0_LSB +: 3] = s.point0;
    w[vcic_pkg::BP1_LSB +: 3] = s.point1;
    w[vcic_pkg::EOIM_BIT]     = s.split;
    w[vcic_pkg::CBP_BIT]      = s.common;
    w[vcic_pkg::FIQ_BIT]      = s.fast | SRE_ALWAYS;
    w[vcic_pkg::ACK_BIT]      = s.ack & ~SRE_ALWAYS;
    w[vcic_pkg::EN1_BIT]      = s.en1;
    w[vcic_pkg::EN0_BIT]      = s.en0;
    return w;
  endfunction

  assign pif.mask        = state.mask;
  assign pif.point0      = state.point0;
  assign pif.point1      = state.point1;
  assign pif.common      = state.common;
  assign pif.cand_prio   = cand_prio;
  assign pif.run_prio    = run_prio;
  assign pif.cand_group1 = cand_group1;

  vcic_prio_check u_check (
    .pif (pif.chk)
  );

  logic enc_hit;
  logic is_type;
  logic is_maint;
  logic is_ctrl;
  logic sig_ok;
  always_comb begin
    next_state = state;
    enc_hit  = sr_valid && sr_op0 == vcic_pkg::ENC_OP0 && sr_op1 == vcic_pkg::ENC_OP1 &&
               sr_crn == vcic_pkg::ENC_CRN && sr_crm == vcic_pkg::ENC_CRM;
    is_type  = enc_hit && sr_op2 == vcic_pkg::OP2_TYPE;
    is_maint = enc_hit && sr_op2 == vcic_pkg::OP2_MAINT;
    is_ctrl  = enc_hit && sr_op2 == vcic_pkg::OP2_CTRL;
    next_state.done  = 1'b0;
    next_state.trap  = 1'b0;
    next_state.drop  = 1'b0;
    next_state.deact = 1'b0;
    if (is_type || is_maint || is_ctrl) begin
      if (!sysreg_enable_hyp) begin
        next_state.trap = 1'b1;
      end else begin
        next_state.done = 1'b1;
        if (is_ctrl && sr_write) begin
          next_state.mask   = sr_wdata[vcic_pkg::PMR_LSB +: 8];
          next_state.point0 = sr_wdata[vcic_pkg::BP0_LSB +: 3];
          next_state.point1 = sr_wdata[vcic_pkg::BP1_LSB +: 3];
          next_state.split  = sr_wdata[vcic_pkg::EOIM_BIT];
          next_state.common = sr_wdata[vcic_pkg::CBP_BIT];
          next_state.fast   = sr_wdata[vcic_pkg::FIQ_BIT];
          next_state.ack    = sr_wdata[vcic_pkg::ACK_BIT];
          next_state.en1    = sr_wdata[vcic_pkg::EN1_BIT];
          next_state.en0    = sr_wdata[vcic_pkg::EN0_BIT];
        end
        if (!sr_write) begin
          next_state.rdata = is_type ? TYPE_VALUE :
                             is_maint ? maintenance_status : vcic_ctrl_word(state);
        end
      end
    end
    // guest-side writes land in the same fields
    if (pmr_wr) begin
      next_state.mask = guest_wdata;
    end
    if (bp0_wr) begin
      next_state.point0 = guest_wdata[2:0];
    end
    if (bp1_wr && !state.common) begin
      next_state.point1 = guest_wdata[2:0];
    end
    // end-of-interrupt handling
    if (group0_end_of_interrupt || group1_end_of_interrupt) begin
      next_state.drop  = 1'b1;
      next_state.deact = !state.split;
    end
    if (deactivation_register && state.split) begin
      next_state.deact = 1'b1;
    end
    // signalling; disabled group stays silent
    sig_ok = cand_valid && pif.may_signal && (cand_group1 ? state.en1 : state.en0);
    next_state.irq = sig_ok && (cand_group1 || !(state.fast | SRE_ALWAYS));
    next_state.fiq = sig_ok && !cand_group1 && (state.fast | SRE_ALWAYS);
    // legacy acknowledge hides group 1 identity
    next_state.ackid = (cand_group1 && !state.ack) ? vcic_pkg::SPURIOUS_G1 : cand_id;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state        <= '0;
      state.mask   <= vcic_pkg::PMR_RESET;
      state.point0 <= vcic_pkg::BP0_RESET;
      state.point1 <= vcic_pkg::BP1_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign sr_done                = state.done;
  assign sr_trap                = state.trap;
  assign sr_rdata               = state.rdata;
  assign priority_mask_register = state.mask;
  assign group0_point_register  = state.point0;
  assign group1_point_register  = vcic_bp1_view(state.point0, state.point1, state.common);
  assign prio_drop              = state.drop;
  assign deactivate             = state.deact;
  assign ack_id                 = state.ackid;
  assign virq                   = state.irq;
  assign vfiq                   = state.fiq;

  // checks
  a_trap_when_off: assert property (@(posedge ref_clk) disable iff (rst)
    sr_valid && !sysreg_enable_hyp && sr_op0 == 2'h3 && sr_op1 == 3'h4 && sr_crn == 4'hc &&
    sr_crm == 4'hb && sr_op2 == 3'h7 |=> sr_trap && !sr_done) else $error("access not trapped");
  a_ctrl_write_seen: assert property (@(posedge ref_clk) disable iff (rst)
    sr_valid && sr_write && sysreg_enable_hyp && sr_op0 == 2'h3 && sr_op1 == 3'h4 && sr_crn == 4'hc &&
    sr_crm == 4'hb && sr_op2 == 3'h7 && !pmr_wr |=> priority_mask_register == $past(sr_wdata[31:24]))
    else $error("mask write not seen");
  a_type_read: assert property (@(posedge ref_clk) disable iff (rst)
    sr_valid && !sr_write && sysreg_enable_hyp && sr_op0 == 2'h3 && sr_op1 == 3'h4 && sr_crn == 4'hc &&
    sr_crm == 4'hb && sr_op2 == 3'h1 |=> sr_rdata == TYPE_VALUE && sr_rdata[18:5] == 14'h0)
    else $error("type read wrong");
  a_bp1_saturate: assert property (@(posedge ref_clk) disable iff (rst)
    state.common && state.point0 == 3'h7 |-> group1_point_register == 3'h7) else $error("bp1 not saturated");
  a_bp1_ignored: assert property (@(posedge ref_clk) disable iff (rst)
    state.common && bp1_wr && !(sr_valid && sr_write) |=> state.point1 == $past(state.point1))
    else $error("bp1 write not ignored");
  a_eoi_deact: assert property (@(posedge ref_clk) disable iff (rst)
    group0_end_of_interrupt && !state.split |=> prio_drop && deactivate) else $error("eoi did not deactivate");
  a_split_eoi: assert property (@(posedge ref_clk) disable iff (rst)
    group1_end_of_interrupt && state.split && !deactivation_register |=> prio_drop && !deactivate)
    else $error("split eoi deactivated");
  a_mask_gate: assert property (@(posedge ref_clk) disable iff (rst)
    cand_prio >= state.mask |=> !virq && !vfiq) else $error("masked interrupt signalled");
  a_group1_off: assert property (@(posedge ref_clk) disable iff (rst)
    cand_group1 && !state.en1 |=> !virq) else $error("disabled group 1 signalled");
  a_fast_route: assert property (@(posedge ref_clk) disable iff (rst)
    vfiq |-> !virq && $past(!cand_group1)) else $error("fast route wrong");
  a_ack_hide: assert property (@(posedge ref_clk) disable iff (rst)
    cand_group1 && !state.ack |=> ack_id == 24'h0003fe) else $error("group 1 identity leaked");
  // signalling gates and acknowledge identity
  a_group0_off: assert property (@(posedge ref_clk) disable iff (rst)
    !cand_group1 && !state.en0 |=> !virq && !vfiq)
    else $error("disabled group 0 signalled");

  a_fast_off: assert property (@(posedge ref_clk) disable iff (rst)
    !(state.fast | SRE_ALWAYS) |=> !vfiq)
    else $error("fast route used while off");

  a_ack_real: assert property (@(posedge ref_clk) disable iff (rst)
    (state.ack || !cand_group1) |=> ack_id == $past(cand_id))
    else $error("real identity not returned");

  // end of interrupt and deactivation
  a_split_dir: assert property (@(posedge ref_clk) disable iff (rst)
    deactivation_register && state.split |=> deactivate)
    else $error("deactivation write lost");

  // unpredictable case resolved as ignore
  a_dir_ignored: assert property (@(posedge ref_clk) disable iff (rst)
    deactivation_register && !state.split && !group0_end_of_interrupt && !group1_end_of_interrupt
    |=> !deactivate)
    else $error("deactivation acted in joint mode");

  // trapped accesses leave state alone
  a_trap_keeps: assert property (@(posedge ref_clk) disable iff (rst)
    sr_valid && !sysreg_enable_hyp && !pmr_wr |=> $stable(priority_mask_register))
    else $error("trapped access changed mask");

  a_one_answer: assert property (@(posedge ref_clk) disable iff (rst)
    !(sr_done && sr_trap))
    else $error("done and trap together");

  // guest view aliasing
  a_pmr_guest: assert property (@(posedge ref_clk) disable iff (rst)
    pmr_wr |=> priority_mask_register == $past(guest_wdata))
    else $error("guest mask write lost");

  a_bp0_guest: assert property (@(posedge ref_clk) disable iff (rst)
    bp0_wr |=> group0_point_register == $past(guest_wdata[2:0]))
    else $error("guest point write lost");

  a_bp1_own: assert property (@(posedge ref_clk) disable iff (rst)
    !state.common |-> group1_point_register == state.point1)
    else $error("group 1 point view wrong");

  a_bp1_plus: assert property (@(posedge ref_clk) disable iff (rst)
    state.common && state.point0 != 3'h7 |-> group1_point_register == state.point0 + 3'h1)
    else $error("group 1 point not one above");

  // read-back layout
  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (rst)
    is_ctrl && !sr_write && sysreg_enable_hyp |=> sr_rdata[17:10] == 8'h0 && sr_rdata[8:5] == 4'h0)
    else $error("reserved control bits set");

  a_idw_legal: assert property (@(posedge ref_clk) disable iff (rst)
    is_type && !sr_write && sysreg_enable_hyp |=> sr_rdata[25:23] <= 3'h1)
    else $error("reserved identifier width");

  a_prio_bits: assert property (@(posedge ref_clk) disable iff (rst)
    is_type && !sr_write && sysreg_enable_hyp |=> sr_rdata[31:29] >= 3'h4 && sr_rdata[28:26] >= 3'h4)
    else $error("too few priority bits");

  c_trap: cover property (@(posedge ref_clk) sr_trap);
  c_fiq: cover property (@(posedge ref_clk) vfiq);
  c_split_deact: cover property (@(posedge ref_clk) state.split && deactivate);
  c_common_read: cover property (@(posedge ref_clk) state.common && group1_point_register != state.point1);
endmodule
`default_nettype wire

// file: testbench/vcic_pe_model.sv
// Purpose: processing element side, offers one pending virtual candidate
// Assumes: offer fields come from the bench, sampled on ref_clk
// Notes:   core runs nothing, so running priority stays at the idle level
`timescale 1ns/100ps
`default_nettype none
module vcic_pe_model (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // offer from the bench
  input  wire logic        want_valid,
  input  wire logic        want_g1,
  input  wire logic [7:0]  want_prio,
  input  wire logic [23:0] want_id,
  // candidate towards the interface
  output logic             cand_valid,
  output logic             cand_group1,
  output logic [7:0]       cand_prio,
  output logic [23:0]      cand_id,
  output logic [7:0]       run_prio
);
  // idle core: any group priority below the lowest level may preempt
  assign run_prio = 8'hff;
  // registered so the candidate changes just after an edge, like real logic
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cand_valid  <= 1'b0;
      cand_group1 <= 1'b0;
      cand_prio   <= 8'hff;
      cand_id     <= 24'h0;
    end else begin
      cand_valid  <= want_valid;
      cand_group1 <= want_g1;
      cand_prio   <= want_prio;
      cand_id     <= want_id;
    end
  end
endmodule
`default_nettype wire

// file: testbench/virtual_cpu_if_control_tb.sv
// Purpose: self-checking bench for the virtual interface control block
// Assumes: design parameters at their defaults
// Notes:   reference keeps the control word as a plain vector
`timescale 1ns/100ps
`default_nettype none
module virtual_cpu_if_control_tb;
  localparam logic [31:0] CMASK = 32'hfffc021f;
  localparam logic [31:0] TYPEV = 32'h90100003;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        sr_valid = 1'b0, sr_write = 1'b0, sysreg_enable_hyp = 1'b1;
  logic [2:0]  sr_op2 = 3'h0;
  logic [31:0] sr_wdata = 32'h0, maintenance_status = 32'h0, sr_rdata, lf = 32'hb665, ctl_m = 32'h004c0000;
  logic        sr_done, sr_trap, prio_drop, deactivate, virq, vfiq;
  logic        pmr_wr = 1'b0, bp0_wr = 1'b0, bp1_wr = 1'b0;
  logic        group0_end_of_interrupt = 1'b0, group1_end_of_interrupt = 1'b0, deactivation_register = 1'b0;
  logic [7:0]  guest_wdata = 8'h0, priority_mask_register, cand_prio, run_prio, want_prio = 8'h0;
  logic [2:0]  group0_point_register, group1_point_register;
  logic        want_valid = 1'b0, want_g1 = 1'b0, cand_valid, cand_group1;
  logic [23:0] want_id = 24'h0, cand_id, ack_id;
  int          err_count = 0, n_tests = 0, cyc = 0;

  always #20 ref_clk = ~ref_clk;

  vcic_ctrl i_dut (
    .ref_clk, .rst, .sr_valid, .sr_write, .sr_op0(vcic_pkg::ENC_OP0), .sr_op1(vcic_pkg::ENC_OP1),
    .sr_crn(vcic_pkg::ENC_CRN), .sr_crm(vcic_pkg::ENC_CRM), .sr_op2, .sr_wdata, .sysreg_enable_hyp,
    .maintenance_status, .sr_done, .sr_trap, .sr_rdata, .pmr_wr, .bp0_wr, .bp1_wr, .guest_wdata,
    .priority_mask_register, .group0_point_register, .group1_point_register, .group0_end_of_interrupt,
    .group1_end_of_interrupt, .deactivation_register, .prio_drop, .deactivate, .cand_valid, .cand_group1,
    .cand_prio, .cand_id, .run_prio, .ack_id, .virq, .vfiq
  );
  vcic_pe_model i_pe (
    .ref_clk, .rst, .want_valid, .want_g1, .want_prio, .want_id,
    .cand_valid, .cand_group1, .cand_prio, .cand_id, .run_prio
  );

  function automatic logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [2:0] bp1v();
    if (!ctl_m[4]) return ctl_m[20:18];
    return (ctl_m[23:21] == 3'h7) ? 3'h7 : ctl_m[23:21] + 3'h1;
  endfunction
  function automatic logic [1:0] irq_e();
    logic on;
    on = want_valid && want_prio < ctl_m[31:24] && (want_g1 ? ctl_m[1] : ctl_m[0]);
    return on ? ((!want_g1 && ctl_m[3]) ? 2'b01 : 2'b10) : 2'b00;
  endfunction

  task automatic results();
    if (err_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // request held one full cycle; answer sampled in the cycle after the taking edge
  task automatic sr(input logic wr, input logic [2:0] op2, input logic [31:0] d, input logic [1:0] dt);
    @(posedge ref_clk);
    #1;
    sr_valid = 1'b1;
    sr_write = wr;
    sr_op2 = op2;
    sr_wdata = d;
    @(posedge ref_clk);
    #1;
    chk({sr_done, sr_trap}, dt);
    sr_valid = 1'b0;
  endtask
  task automatic pulse(ref logic s);
    @(posedge ref_clk);
    #1;
    s = 1'b1;
    @(posedge ref_clk);
    #1;
    s = 1'b0;
  endtask
  task automatic rd_ctl();
    sr(1'b0, 3'h7, 32'h0, 2'b10);
    chk(sr_rdata, ctl_m);
    chk({priority_mask_register, group0_point_register}, {ctl_m[31:24], ctl_m[23:21]});
    chk(group1_point_register, bp1v());
  endtask
  task automatic wr_ctl(input logic [31:0] d);
    sr(1'b1, 3'h7, d, 2'b10);
    ctl_m = d & CMASK;
    rd_ctl();
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      results();
    end
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    #1 rst = 1'b0;
    rd_ctl();
    sr(1'b1, 3'h1, lf, 2'b10);
    sr(1'b0, 3'h1, 32'h0, 2'b10);
    chk(sr_rdata, TYPEV);
    maintenance_status = rnd(lf);
    sr(1'b0, 3'h2, 32'h0, 2'b10);
    chk(sr_rdata, maintenance_status);
    sr(1'b1, 3'h3, lf, 2'b00);
    // random control words, then guest writes through the aliased view
    for (int k = 0; k < 8; k++) begin
      lf = rnd(lf);
      wr_ctl({lf[31:5], k[0], lf[3:0]});
      guest_wdata = {lf[7:3], k[2:0]};
      pulse(pmr_wr);
      pulse(bp0_wr);
      pulse(bp1_wr);
      ctl_m[31:24] = guest_wdata;
      ctl_m[23:21] = guest_wdata[2:0];
      if (!ctl_m[4]) ctl_m[20:18] = guest_wdata[2:0];
      rd_ctl();
    end
    sysreg_enable_hyp = 1'b0;
    sr(1'b1, 3'h7, ~ctl_m, 2'b01);
    sr(1'b0, 3'h1, 32'h0, 2'b01);
    sysreg_enable_hyp = 1'b1;
    rd_ctl();
    for (int m = 0; m < 2; m++) begin
      wr_ctl((ctl_m & 32'hfffffdff) | {22'h0, m[0], 9'h0});
      pulse(group0_end_of_interrupt);
      chk({prio_drop, deactivate}, {1'b1, ~m[0]});
      pulse(group1_end_of_interrupt);
      chk({prio_drop, deactivate}, {1'b1, ~m[0]});
      pulse(deactivation_register);
      chk({prio_drop, deactivate}, {1'b0, m[0]});
    end
    // every enable, route and ack setting, priorities either side of the mask
    for (int i = 0; i < 32; i++) begin
      lf = rnd(lf);
      wr_ctl({8'h80, 20'h4c000, i[3:0]});
      want_valid = (i != 30);
      want_g1 = i[4];
      want_prio = (i % 3 == 0) ? 8'h80 : (i % 3 == 1) ? 8'h7f : 8'h10;
      want_id = lf[23:0];
      repeat (3) @(posedge ref_clk);
      #1;
      chk({virq, vfiq}, irq_e());
      if (want_valid) chk(ack_id, (want_g1 && !ctl_m[2]) ? 24'h3fe : want_id);
    end
    results();
  end
endmodule
`default_nettype wire
